// ### core/ccwp_port.sv
// Codec control word port: serial write receiver and register decode
//
// How it works
// [RULE1] Word: seven address bits, nine value bits
// [RULE2] Host sends start, address, two bytes, stop
// [RULE3] Eleven nine-bit registers selected by address
// [RULE4] Reset register: ones enter, zeros leave reset
// [RULE5] Power-down register at address six
// [RULE6] Analog path register takes its word
// [RULE7] Digital path register takes its word
// [RULE8] Sample rate register takes its word
// [RULE9] Activation register switches interface on
// [RULE10] Interface format register takes its word
// [RULE11] Line input volume registers, left and right
// [RULE12] Headphone volume registers, left and right
// [RULE13] Host controller set up by host
// [RULE14] Host targets address 0x1A, two bytes
// [RULE15] Acknowledge bytes; commit after second byte
// [RULE16] Unknown register addresses leave state unchanged
`timescale 1ns/1ns
module ccwp_port (
   input  wire logic                clk,
   input  wire logic                nrst,
   input  wire logic                scl_i,
   input  wire logic                sda_i,
   output logic                     sda_o,
   output logic                     sda_oe,
   output ccwp_pkg::ccwp_cfg_t      cfg_o,
   output logic                     in_reset_o,
   output logic                     word_valid_o,
   output ccwp_pkg::ccwp_word_t     word_o,
   output logic                     busy_o
);

   ccwp_pkg::ccwp_bus_t   bus_s;         // Synchronised lines
   ccwp_pkg::ccwp_bus_t   bus_d_r;       // Lines one cycle earlier
   ccwp_pkg::ccwp_state_t state_r;       // Sequencer state
   ccwp_pkg::ccwp_state_t state_nxt;     // Next sequencer state
   logic [3:0]            cnt_r;         // Bits taken in this byte
   logic [7:0]            shift_r;       // Incoming byte
   logic [7:0]            byte1_r;       // First data byte
   logic                  sda_oe_r;      // Acknowledge drive
   logic                  sda_o_r;       // Driven level, always low
   logic                  in_reset_r;    // Codec held in reset mode
   logic                  word_valid_r;  // Word committed pulse
   ccwp_pkg::ccwp_word_t  word_r;        // Last committed word
   logic                  busy_r;        // Inside a transaction
   logic [10:0][8:0]      regs;          // Register file contents
   logic                  scl_rise;      // Clock rising edge
   logic                  scl_fall;      // Clock falling edge
   logic                  start_c;       // Start or repeated start
   logic                  stop_c;        // Stop condition
   logic                  done2_c;       // Second data byte complete
   ccwp_pkg::ccwp_word_t  word_c;        // Word being committed
   logic                  mapped_c;      // Word addresses a register
   logic [3:0]            widx_c;        // Register file index
   logic                  we_c;          // Register file write

   // Both lines come from another party's clock, so they are synchronised
   ccwp_sync #(
      .W (2)
   ) u_sync (
      .clk  (clk),
      .nrst (nrst),
      .d    ({scl_i, sda_i}),
      .q    (bus_s)
   );

   // Previous sample for edge detection on the synchronised lines
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         bus_d_r <= '1;
      end else begin
         bus_d_r <= bus_s;
      end
   end

   // Edges and bus conditions; start and stop only while the clock is high
   assign scl_rise = bus_s.scl && !bus_d_r.scl;
   assign scl_fall = !bus_s.scl && bus_d_r.scl;
   assign start_c  = bus_s.scl && bus_d_r.scl && bus_d_r.sda && !bus_s.sda;
   assign stop_c   = bus_s.scl && bus_d_r.scl && !bus_d_r.sda && bus_s.sda;

   // Next state: stop and start act at once; every other phase change happens on a falling clock edge
   always_comb begin
      state_nxt = state_r;
      if (stop_c) begin
         state_nxt = ccwp_pkg::CCWP_ST_IDLE;
      end else if (start_c) begin
         state_nxt = ccwp_pkg::CCWP_ST_ADDR;
      end else if (scl_fall) begin
         case (state_r)
            ccwp_pkg::CCWP_ST_ADDR: begin
               // Only a write to our own address is acknowledged
               if (cnt_r == ccwp_pkg::CCWP_BYTE_BITS) begin
                  if (shift_r == {ccwp_pkg::CCWP_DEV_ADDR, 1'b0}) begin // RULE14
                     state_nxt = ccwp_pkg::CCWP_ST_ADDR_ACK;
                  end else begin
                     state_nxt = ccwp_pkg::CCWP_ST_IGNORE;
                  end
               end
            end
            ccwp_pkg::CCWP_ST_ADDR_ACK: begin
               state_nxt = ccwp_pkg::CCWP_ST_BYTE1;
            end
            ccwp_pkg::CCWP_ST_BYTE1: begin
               if (cnt_r == ccwp_pkg::CCWP_BYTE_BITS) begin
                  state_nxt = ccwp_pkg::CCWP_ST_ACK1; // RULE15
               end
            end
            ccwp_pkg::CCWP_ST_ACK1: begin
               state_nxt = ccwp_pkg::CCWP_ST_BYTE2;
            end
            ccwp_pkg::CCWP_ST_BYTE2: begin
               if (cnt_r == ccwp_pkg::CCWP_BYTE_BITS) begin
                  state_nxt = ccwp_pkg::CCWP_ST_ACK2; // RULE15
               end
            end
            ccwp_pkg::CCWP_ST_ACK2: begin
               // A word is exactly two bytes; anything more is refused
               state_nxt = ccwp_pkg::CCWP_ST_IGNORE; // RULE2
            end
            default: begin
               state_nxt = state_r;
            end
         endcase
      end
   end

   // Sequencer state register
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         state_r <= ccwp_pkg::CCWP_ST_IDLE;
      end else begin
         state_r <= state_nxt;
      end
   end

   // Bit counter restarts with every phase, counts rising edges in bytes
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         cnt_r <= 4'h0;
      end else if (state_nxt != state_r) begin
         cnt_r <= 4'h0;
      end else if (scl_rise && (cnt_r != ccwp_pkg::CCWP_BYTE_BITS)) begin
         cnt_r <= cnt_r + 4'h1;
      end
   end

   // Data is sampled on the rising clock edge, most significant bit first
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         shift_r <= 8'h00;
      end else if (scl_rise) begin
         shift_r <= {shift_r[6:0], bus_s.sda};
      end
   end

   // First data byte is held until the second completes
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         byte1_r <= 8'h00;
      end else if ((state_r == ccwp_pkg::CCWP_ST_BYTE1) &&
                   (state_nxt == ccwp_pkg::CCWP_ST_ACK1)) begin
         byte1_r <= shift_r;
      end
   end

   // Acknowledge: pull the data line low for the whole ninth clock
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         sda_oe_r <= 1'b0;
      end else begin
         sda_oe_r <= (state_nxt == ccwp_pkg::CCWP_ST_ADDR_ACK) ||
                     (state_nxt == ccwp_pkg::CCWP_ST_ACK1) ||
                     (state_nxt == ccwp_pkg::CCWP_ST_ACK2); // RULE15
      end
   end

   // The port only ever drives low, open-drain style
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         sda_o_r <= 1'b0;
      end else begin
         sda_o_r <= 1'b0;
      end
   end

   // Word assembly: upper seven bits address, low bit is value bit nine
   assign done2_c = (state_r == ccwp_pkg::CCWP_ST_BYTE2) &&
                    (state_nxt == ccwp_pkg::CCWP_ST_ACK2);
   assign word_c  = {byte1_r, shift_r}; // RULE1

   // Address decode onto the eleven storage words
   always_comb begin
      mapped_c = 1'b1;
      widx_c   = word_c.addr[3:0];
      case (word_c.addr)
         ccwp_pkg::CCWP_A_LINE_IN_L,              // RULE11
         ccwp_pkg::CCWP_A_LINE_IN_R,              // RULE11
         ccwp_pkg::CCWP_A_HP_L,                   // RULE12
         ccwp_pkg::CCWP_A_HP_R,                   // RULE12
         ccwp_pkg::CCWP_A_ANALOG,                 // RULE6
         ccwp_pkg::CCWP_A_DIGITAL,                // RULE7
         ccwp_pkg::CCWP_A_POWER_DOWN,             // RULE5
         ccwp_pkg::CCWP_A_FORMAT,                 // RULE10
         ccwp_pkg::CCWP_A_RATE,                   // RULE8
         ccwp_pkg::CCWP_A_ACTIVE: begin           // RULE9
            widx_c = word_c.addr[3:0]; // RULE3
         end
         ccwp_pkg::CCWP_A_RESET: begin
            widx_c = ccwp_pkg::CCWP_IDX_RESET; // RULE4
         end
         default: begin
            // No such register: the word is dropped
            mapped_c = 1'b0; // RULE16
         end
      endcase
   end

   // Commit only once the second byte is fully in
   assign we_c = done2_c && mapped_c; // RULE15

   // Register storage
   ccwp_regfile u_regs (
      .clk   (clk),
      .nrst  (nrst),
      .we    (we_c),
      .widx  (widx_c),
      .wdata (word_c.value),
      .regs  (regs)
   );

   // Reset mode flag; other values in the reset register leave it as is
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         in_reset_r <= 1'b0;
      end else if (we_c && (widx_c == ccwp_pkg::CCWP_IDX_RESET)) begin
         if (word_c.value == ccwp_pkg::CCWP_RST_ENTER) begin
            in_reset_r <= 1'b1; // RULE4
         end else if (word_c.value == ccwp_pkg::CCWP_RST_LEAVE) begin
            in_reset_r <= 1'b0; // RULE4
         end
      end
   end

   // Committed word report, one cycle pulse with the word held after
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         word_valid_r <= 1'b0;
         word_r       <= '0;
      end else begin
         word_valid_r <= we_c;
         if (we_c) begin
            word_r <= word_c;
         end
      end
   end

   // Busy while a transaction is open
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         busy_r <= 1'b0;
      end else begin
         busy_r <= (state_nxt != ccwp_pkg::CCWP_ST_IDLE);
      end
   end

   // Outputs, all straight from flops
   assign sda_o        = sda_o_r;
   assign sda_oe       = sda_oe_r;
   assign cfg_o        = ccwp_pkg::ccwp_cfg_t'(regs);
   assign in_reset_o   = in_reset_r;
   assign word_valid_o = word_valid_r;
   assign word_o       = word_r;
   assign busy_o       = busy_r;

   // Checks on the port's own behaviour
   default clocking cb @(posedge clk); endclocking
   default disable iff (!nrst);

   sequence s_byte2_done;
      done2_c;
   endsequence

   sequence s_byte1_done;
      (state_r == ccwp_pkg::CCWP_ST_BYTE1) && (state_nxt == ccwp_pkg::CCWP_ST_ACK1);
   endsequence

   property p_word_split;
      s_byte2_done and mapped_c |=> word_valid_o &&
         (word_o == {$past(byte1_r), $past(shift_r)});
   endproperty
   a_word_split: assert property (p_word_split) else $error("word split wrong"); // RULE1

   property p_reg_write;
      we_c |=> regs[$past(widx_c)] == $past(word_c.value);
   endproperty
   a_reg_write: assert property (p_reg_write) else $error("register not written"); // RULE3

   property p_reset_enter;
      we_c && (widx_c == ccwp_pkg::CCWP_IDX_RESET) &&
         (word_c.value == ccwp_pkg::CCWP_RST_ENTER)
         |=> in_reset_o && (cfg_o.power_down == ccwp_pkg::CCWP_REG_RST_VAL);
   endproperty
   a_reset_enter: assert property (p_reset_enter) else $error("reset not entered"); // RULE4

   property p_reset_leave;
      we_c && (widx_c == ccwp_pkg::CCWP_IDX_RESET) &&
         (word_c.value == ccwp_pkg::CCWP_RST_LEAVE) |=> !in_reset_o;
   endproperty
   a_reset_leave: assert property (p_reset_leave) else $error("reset not left"); // RULE4

   property p_power_down;
      we_c && (word_c.addr == ccwp_pkg::CCWP_A_POWER_DOWN)
         |=> cfg_o.power_down == $past(word_c.value);
   endproperty
   a_power_down: assert property (p_power_down) else $error("power word lost"); // RULE5

   property p_rate;
      we_c && (word_c.addr == ccwp_pkg::CCWP_A_RATE)
         |=> (cfg_o.sample_rate == $past(word_c.value)) && $stable(cfg_o.iface_active);
   endproperty
   a_rate: assert property (p_rate) else $error("rate word lost"); // RULE8

   property p_active;
      we_c && (word_c.addr == ccwp_pkg::CCWP_A_ACTIVE)
         |=> cfg_o.iface_active == $past(word_c.value);
   endproperty
   a_active: assert property (p_active) else $error("activation word lost"); // RULE9

   property p_ack1;
      s_byte1_done |=> sda_oe && (state_r == ccwp_pkg::CCWP_ST_ACK1);
   endproperty
   a_ack1: assert property (p_ack1) else $error("byte not acknowledged"); // RULE15

   property p_late_commit;
      we_c |-> (state_r == ccwp_pkg::CCWP_ST_BYTE2) &&
               (cnt_r == ccwp_pkg::CCWP_BYTE_BITS) && scl_fall;
   endproperty
   a_late_commit: assert property (p_late_commit) else $error("early commit"); // RULE15

   property p_unmapped;
      s_byte2_done and !mapped_c |=> $stable(cfg_o) && !word_valid_o;
   endproperty
   a_unmapped: assert property (p_unmapped) else $error("unmapped word stored"); // RULE16

endmodule // ccwp_port

// ### core/ccwp_regfile.sv
// Configuration register file of the codec control port
`timescale 1ns/1ns
module ccwp_regfile (
   input  wire logic       clk,
   input  wire logic       nrst,
   input  wire logic       we,
   input  wire logic [3:0] widx,
   input  wire logic [8:0] wdata,
   output logic [10:0][8:0] regs
);

   logic [8:0] regs_r [0:ccwp_pkg::CCWP_NUM_REGS-1];   // Storage
   logic       clr_c;                                   // Reset mode entry

   // Entering reset mode returns every other register to its default
   assign clr_c = we && (widx == ccwp_pkg::CCWP_IDX_RESET)
                     && (wdata == ccwp_pkg::CCWP_RST_ENTER);

   // One storage word per entry, outputs come straight from the flops
   for (genvar i = 0; i < ccwp_pkg::CCWP_NUM_REGS; i++) begin : g_ent
      always_ff @(posedge clk or negedge nrst) begin
         if (!nrst) begin
            regs_r[i] <= ccwp_pkg::CCWP_REG_RST_VAL;
         end else if (we && (widx == 4'(i))) begin
            regs_r[i] <= wdata;
         end else if (clr_c) begin
            regs_r[i] <= ccwp_pkg::CCWP_REG_RST_VAL;
         end
      end
      assign regs[i] = regs_r[i];
   end

endmodule // ccwp_regfile

// ### core/ccwp_sync.sv
// Two-stage synchroniser for the serial bus lines
`timescale 1ns/1ns
module ccwp_sync #(
   parameter int W = 2
) (
   input  wire logic         clk,
   input  wire logic         nrst,
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);

   logic [W-1:0] meta_r;    // First stage, read only by the second

   // One pair of flops per line; idle bus level is high
   for (genvar i = 0; i < W; i++) begin : g_bit
      always_ff @(posedge clk or negedge nrst) begin
         if (!nrst) begin
            meta_r[i] <= 1'b1;
            q[i]      <= 1'b1;
         end else begin
            meta_r[i] <= d[i];
            q[i]      <= meta_r[i];
         end
      end
   end

endmodule // ccwp_sync

// ### pkg/ccwp_pkg.sv
// Package with constants and types for the codec control word port
package ccwp_pkg;

   // Bus target address that the port answers to
   localparam logic [6:0] CCWP_DEV_ADDR     = 7'h1A;

   // Register file geometry and synchroniser depth
   localparam int         CCWP_NUM_REGS     = 11;
   localparam int         CCWP_REG_W        = 9;
   localparam int         CCWP_SYNC_STAGES  = 2;

   // Control word register addresses
   localparam logic [6:0] CCWP_A_LINE_IN_L  = 7'h00;
   localparam logic [6:0] CCWP_A_LINE_IN_R  = 7'h01;
   localparam logic [6:0] CCWP_A_HP_L       = 7'h02;
   localparam logic [6:0] CCWP_A_HP_R       = 7'h03;
   localparam logic [6:0] CCWP_A_ANALOG     = 7'h04;
   localparam logic [6:0] CCWP_A_DIGITAL    = 7'h05;
   localparam logic [6:0] CCWP_A_POWER_DOWN = 7'h06;
   localparam logic [6:0] CCWP_A_FORMAT     = 7'h07;
   localparam logic [6:0] CCWP_A_RATE       = 7'h08;
   localparam logic [6:0] CCWP_A_ACTIVE     = 7'h09;
   localparam logic [6:0] CCWP_A_RESET      = 7'h0F;

   // Index of the reset register inside the register file
   localparam logic [3:0] CCWP_IDX_RESET    = 4'hA;

   // Register values
   localparam logic [8:0] CCWP_REG_RST_VAL  = 9'h000;
   localparam logic [8:0] CCWP_RST_ENTER    = 9'h1FF;
   localparam logic [8:0] CCWP_RST_LEAVE    = 9'h000;

   // Bits in one serial byte
   localparam logic [3:0] CCWP_BYTE_BITS    = 4'h8;

   // Serial receive sequencer states
   typedef enum logic [2:0] {
      CCWP_ST_IDLE     = 3'b000,
      CCWP_ST_ADDR     = 3'b001,
      CCWP_ST_ADDR_ACK = 3'b010,
      CCWP_ST_BYTE1    = 3'b011,
      CCWP_ST_ACK1     = 3'b100,
      CCWP_ST_BYTE2    = 3'b101,
      CCWP_ST_ACK2     = 3'b110,
      CCWP_ST_IGNORE   = 3'b111
   } ccwp_state_t;

   // All configuration registers, highest index first
   typedef struct packed {
      logic [8:0] reset;
      logic [8:0] iface_active;
      logic [8:0] sample_rate;
      logic [8:0] iface_format;
      logic [8:0] power_down;
      logic [8:0] digital_path;
      logic [8:0] analog_path;
      logic [8:0] hp_r;
      logic [8:0] hp_l;
      logic [8:0] line_in_r;
      logic [8:0] line_in_l;
   } ccwp_cfg_t;

   // Sampled serial bus lines
   typedef struct packed {
      logic scl;
      logic sda;
   } ccwp_bus_t;

   // One decoded control word
   typedef struct packed {
      logic [6:0] addr;
      logic [8:0] value;
   } ccwp_word_t;

endpackage

// ### testbench/ccwp_host_model.sv
// Behavioural host bus master that drives the serial clock and data line
`timescale 1ns/1ns
module ccwp_host_model #(
   parameter int HALF = 4             // Clock cycles per serial clock phase
) (
   input  wire logic clk,             // System clock, changes land on its falling edge
   input  wire logic sda_o,           // Level the port drives
   input  wire logic sda_oe,          // Port pulls the data line
   output logic      scl,             // Serial clock, idles high between frames
   output logic      sda              // Resolved data line level
);
   logic pull_low;                    // Host pulls the data line low
   int   extra;                       // Added high time; a slow host sets it

   // Open-drain line with pull-up: a released line reads high, never the last value
   assign sda = (pull_low || (sda_oe && !sda_o)) ? 1'b0 : 1'b1;

   // Idle bus at time zero
   initial begin
      scl = 1'b1;
      pull_low = 1'b0;
      extra = 0;
   end

   // Wait a number of falling clock edges
   task automatic tick(input int n);
      repeat (n) @(negedge clk);
   endtask

   // Start: data falls while the clock is high
   task automatic start_cond();
      tick(HALF);
      pull_low = 1'b1;
      tick(HALF);
      scl = 1'b0;
   endtask

   // Stop: data rises while the clock is high
   task automatic stop_cond();
      tick(HALF / 2);
      pull_low = 1'b1;
      tick(HALF);
      scl = 1'b1;
      tick(HALF);
      pull_low = 1'b0;
      tick(HALF);
   endtask

   // One byte, most significant bit first, then the acknowledge clock
   task automatic send_byte(input logic [7:0] b, output logic ack);
      for (int i = 7; i >= 0; i--) begin
         tick(HALF / 2);
         pull_low = !b[i];            // Data only changes while the clock is low
         tick(HALF / 2);
         scl = 1'b1;
         tick(HALF + extra);
         scl = 1'b0;
      end
      tick(HALF / 2);
      pull_low = 1'b0;
      tick(HALF / 2);
      scl = 1'b1;
      tick(HALF - 1 + extra);
      ack = !sda;                     // Sampled late in the high phase
      tick(1);
      scl = 0;
      // Extra low time: the port lets go of the line some cycles after this fall
      tick(HALF);
   endtask

   // Address and first byte only, then the clock parks high with data released,
   // so the next start is a repeated start that must discard the half word
   task automatic part_frame(input logic [7:0] dev, input logic [7:0] b1);
      logic a;
      start_cond();
      send_byte(dev, a);
      send_byte(b1, a);
      tick(HALF / 2);
      pull_low = 1'b0;
      tick(HALF / 2);
      scl = 1'b1;
   endtask

   // Whole frame: start, n bytes, stop; acks[k] tells whether byte k was taken
   task automatic frame(input logic [31:0] bytes, input int n, output logic [3:0] acks);
      logic a;
      acks = 4'h0;
      start_cond();
      for (int k = 0; k < n; k++) begin
         send_byte(bytes[31 - 8 * k -: 8], a);
         acks[k] = a;
      end
      stop_cond();
   endtask
endmodule // ccwp_host_model

// ### testbench/tb_ccwp_port.sv
// Self-checking bench for the codec control word port
`timescale 1ns/1ns
module tb_ccwp_port;
   logic                 clk;              // System clock, 50 MHz
   logic                 nrst;             // Asynchronous reset, active low
   logic                 scl;              // Serial clock from host model
   logic                 sda;              // Resolved data line
   logic                 sda_o;            // Port drive level
   logic                 sda_oe;           // Port drive enable
   ccwp_pkg::ccwp_cfg_t  cfg;              // Register outputs
   logic                 in_reset;         // Reset mode flag
   logic                 word_valid;       // Commit pulse
   ccwp_pkg::ccwp_word_t word;             // Last committed word
   logic                 busy;             // Frame in progress
   logic [98:0]          shadow = '0;      // Expected register contents
   logic                 ir_exp = 1'b0;    // Expected reset mode flag
   logic                 busy_seen = 1'b0; // Busy went high at some point
   int                   n_fail = 0;       // Mismatches
   int                   n_compared = 0;   // Comparisons made
   int                   n_valid = 0;      // Commit pulses seen
   logic [7:0]           dev_w;            // Target address byte for a write
   logic [15:0]          words [10] = '{16'h0C07, 16'h0810, 16'h0A01, 16'h1022, 16'h1201,
                                        16'h0E43, 16'h0117, 16'h0317, 16'h05FF, 16'h07FF};

   assign dev_w = {ccwp_pkg::CCWP_DEV_ADDR, 1'b0};

   ccwp_port u_ccwp_port (
      .clk          (clk),
      .nrst         (nrst),
      .scl_i        (scl),
      .sda_i        (sda),
      .sda_o        (sda_o),
      .sda_oe       (sda_oe),
      .cfg_o        (cfg),
      .in_reset_o   (in_reset),
      .word_valid_o (word_valid),
      .word_o       (word),
      .busy_o       (busy)
   );

   ccwp_host_model u_ccwp_host_model (
      .clk    (clk),
      .sda_o  (sda_o),
      .sda_oe (sda_oe),
      .scl    (scl),
      .sda    (sda)
   );

   // Clock generator
   always #10 clk = ~clk;

   // Count commit pulses; a pulse that stretches counts twice and shows up
   always @(posedge clk) begin
      if (word_valid === 1'b1) n_valid <= n_valid + 1;
      if (busy === 1'b1) busy_seen <= 1'b1;
   end

   // Compare and report
   task automatic check(input string what, input logic [98:0] seen, input logic [98:0] exp);
      n_compared++;
      if (seen !== exp) begin
         n_fail++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask

   // Verdict and end of run
   task automatic test_done();
      $display("compared %0d failed %0d", n_compared, n_fail);
      if (n_fail == 0 && n_compared > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   // One frame, then compare acks, registers, flags against the expected model
   task automatic run(input logic [31:0] bytes, input int n, input logic [3:0] exp_ack);
      logic [3:0] acks;
      logic [6:0] a;
      logic [8:0] v;
      logic       mapped;
      int         v0;
      a = bytes[23:17];
      v = bytes[16:8];
      mapped = (bytes[31:24] == dev_w) && (n >= 3) && (a <= 7'h09 || a == 7'h0F);
      v0 = n_valid;
      u_ccwp_host_model.frame(bytes, n, acks);
      if (mapped) begin
         if (a == 7'h0F && v == 9'h1FF) begin
            shadow = {9'h1FF, 90'h0};  // Entering reset mode clears the rest
            ir_exp = 1'b1;
         end else if (a == 7'h0F) begin
            shadow[90 +: 9] = v;
            if (v == 9'h000) ir_exp = 1'b0;
         end else begin
            shadow[int'(a) * 9 +: 9] = v;
         end
         check("word", word, {a, v});
      end
      u_ccwp_host_model.tick(4);
      check("ack", acks, exp_ack);
      check("regs", cfg, shadow);
      check("in_reset", in_reset, ir_exp);
      check("valid_count", n_valid - v0, mapped);
      check("busy", busy, 1'b0);
   endtask

   // Watchdog: a hang counts as a mismatch
   initial begin
      repeat (60000) @(posedge clk);
      n_fail++;
      test_done();
   end

   // Main sequence
   initial begin
      clk = 1'b0;
      nrst = 1'b0;
      repeat (3) @(negedge clk);
      nrst = 1'b1;
      repeat (4) @(negedge clk);
      check("regs_after_reset", cfg, 99'h0);
      run({dev_w, 16'h1E00, 8'h00}, 3, 4'h7);
      for (int i = 0; i < 10; i++) begin
         run({dev_w, words[i], 8'h00}, 3, 4'h7);
      end
      u_ccwp_host_model.extra = 12;                      // Slow host
      run({dev_w, 16'h1FFF, 8'h00}, 3, 4'h7);
      u_ccwp_host_model.extra = 0;
      run({dev_w, 16'h1E55, 8'h00}, 3, 4'h7);
      run({dev_w, 16'h0C07, 8'h00}, 3, 4'h7);
      run({dev_w, 16'h1E00, 8'h00}, 3, 4'h7);
      run({dev_w, 16'h1455, 8'h00}, 3, 4'h7);
      u_ccwp_host_model.part_frame(dev_w, 8'h12);
      run({dev_w, 16'h1022, 8'h00}, 3, 4'h7);
      run({8'h36, 16'h0C00, 8'h00}, 3, 4'h0);
      run({dev_w | 8'h01, 16'h0C00, 8'h00}, 3, 4'h0);
      run({dev_w, 16'h0C1F, 8'h00}, 2, 4'h3);
      run({dev_w, 16'h0CAA, 8'h5A}, 4, 4'h7);
      check("busy_seen", busy_seen, 1'b1);
      test_done();
   end
endmodule // tb_ccwp_port
